//--- rtl/bscrc_pkg.sv
// Package for the byte-stream checksum unit: register map, fields, constants.
// Assumes an AHB-Lite slave with 32-bit data, one register per aligned word.
package bscrc_pkg;
  localparam logic [7:0] BSCRC_OFS_CTRL = 8'h00;
  localparam logic [7:0] BSCRC_OFS_INPUT = 8'h04;
  localparam logic [7:0] BSCRC_OFS_DATA = 8'h08;
  localparam logic [7:0] BSCRC_OFS_MIRROR = 8'h0C;
  localparam logic [7:0] BSCRC_OFS_STATUS = 8'h10;
  localparam int BSCRC_ADDR_W = 8;
  localparam int BSCRC_CTRL_PTR_LO = 0;
  localparam int BSCRC_CTRL_VAL = 2;
  localparam int BSCRC_CTRL_INIT = 3;
  localparam int BSCRC_CTRL_SEL = 4;
  localparam int BSCRC_FIFO_DEPTH = 32;
  localparam int BSCRC_BITS_PER_BYTE = 8;
  localparam logic [15:0] BSCRC_POLY16 = 16'h1021;
  localparam logic [31:0] BSCRC_POLY32_REFL = 32'hEDB88320;
  localparam logic [31:0] BSCRC_INIT_ONES = 32'hFFFFFFFF;
  localparam logic [31:0] BSCRC_INIT_ZERO = 32'h00000000;
  localparam logic [1:0] BSCRC_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] BSCRC_HTRANS_SEQ = 2'h3;
endpackage

//--- rtl/bscrc_fifo.sv
// Flop-based FIFO with valid/ready on both sides.
// Assumes one clock and an active-low asynchronous reset.
module bscrc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
  } bscrc_fifo_st_t;
  bscrc_fifo_st_t st_reg;
  bscrc_fifo_st_t st_next;
  logic push;
  logic pop;

  assign in_ready = (st_reg.cnt != (AW+1)'(DEPTH));
  assign out_valid = (st_reg.cnt != '0);
  assign out_data = st_reg.mem[st_reg.rd];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    st_next = st_reg;
    if (push) begin
      st_next.mem[st_reg.wr] = in_data;
      st_next.wr = (st_reg.wr == AW'(DEPTH-1)) ? '0 : st_reg.wr + AW'(1);
    end
    if (pop) begin
      st_next.rd = (st_reg.rd == AW'(DEPTH-1)) ? '0 : st_reg.rd + AW'(1);
    end
    if (push && !pop) begin
      st_next.cnt = st_reg.cnt + (AW+1)'(1);
    end else if (pop && !push) begin
      st_next.cnt = st_reg.cnt - (AW+1)'(1);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule

//--- rtl/bscrc_top.sv
// Byte-stream checksum unit: CRC-16 (0x1021, MSB first) or reflected CRC-32,
// with indirect result window, byte pointer and bit-mirror helper register.
// Assumes a single AHB-Lite master; input bytes queue in a FIFO.
module bscrc_top
  import bscrc_pkg::*;
#(
  parameter int FIFO_DEPTH = BSCRC_FIFO_DEPTH
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp
);
  typedef struct packed {
    logic ph_act;
    logic ph_write;
    logic [BSCRC_ADDR_W-1:0] ph_addr;
    logic polynomial_select;
    logic start_value_select;
    logic [1:0] result_byte_pointer;
    logic [31:0] result;
    logic [7:0] bit_mirror_register;
    logic [31:0] rdata;
  } bscrc_st_t;

  bscrc_st_t st_reg;
  bscrc_st_t st_next;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic [7:0] fifo_out_data;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic addr_phase;
  logic [BSCRC_ADDR_W-1:0] win_addr;

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  function automatic logic [31:0] crc_byte(input logic [31:0] acc, input logic [7:0] din,
                                           input logic sel16);
    logic [15:0] c16;
    logic [31:0] c32;
    c16 = acc[15:0] ^ {din, 8'h00};
    c32 = acc ^ {24'h000000, din};
    for (int i = 0; i < BSCRC_BITS_PER_BYTE; i++) begin
      if (c16[15]) begin
        c16 = {c16[14:0], 1'b0} ^ BSCRC_POLY16;
      end else begin
        c16 = {c16[14:0], 1'b0};
      end
      if (c32[0]) begin
        c32 = {1'b0, c32[31:1]} ^ BSCRC_POLY32_REFL;
      end else begin
        c32 = {1'b0, c32[31:1]};
      end
    end
    crc_byte = sel16 ? {acc[31:16], c16} : c32;
  endfunction

  // Byte lane selected by pointer; in 16-bit mode codes 2 and 3 alias 0 and 1
  function automatic logic [1:0] lane(input logic [1:0] ptr, input logic sel16);
    lane = sel16 ? {1'b0, ptr[0]} : ptr;
  endfunction

  function automatic logic [7:0] mirror(input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      mirror[i] = b[7-i];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Input byte queue

  bscrc_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .hclk(hclk),
    .hresetn(hresetn),
    .in_data(hwdata[7:0]),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .out_data(fifo_out_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave

  assign addr_phase = hsel && hready &&
                      (htrans == BSCRC_HTRANS_NONSEQ || htrans == BSCRC_HTRANS_SEQ);
  assign win_addr = haddr[BSCRC_ADDR_W-1:0];
  // Stall an input write while the queue is full
  assign hreadyout = !(st_reg.ph_act && st_reg.ph_write &&
                       st_reg.ph_addr == BSCRC_OFS_INPUT && !fifo_in_ready);
  assign hresp = 1'b0;
  assign hrdata = st_reg.rdata;
  assign fifo_in_valid = st_reg.ph_act && st_reg.ph_write && st_reg.ph_addr == BSCRC_OFS_INPUT;
  // The queue holds its next byte while a control write with the init bit loads the result
  assign fifo_out_ready = !(st_reg.ph_act && st_reg.ph_write &&
                            st_reg.ph_addr == BSCRC_OFS_CTRL && hwdata[BSCRC_CTRL_INIT]);

  always_comb begin
    logic [1:0] ln;
    logic [7:0] wb;
    ln = lane(st_reg.result_byte_pointer, st_reg.polynomial_select);
    wb = hwdata[7:0];
    st_next = st_reg;
    // Background update from queue, one byte per cycle
    if (fifo_out_valid && fifo_out_ready) begin
      st_next.result = crc_byte(st_reg.result, fifo_out_data, st_reg.polynomial_select);
    end
    // Write data phase
    if (st_reg.ph_act && st_reg.ph_write && hreadyout) begin
      case (st_reg.ph_addr)
        BSCRC_OFS_CTRL: begin
          st_next.polynomial_select = hwdata[BSCRC_CTRL_SEL];
          st_next.start_value_select = hwdata[BSCRC_CTRL_VAL];
          st_next.result_byte_pointer = hwdata[BSCRC_CTRL_PTR_LO +: 2];
          if (hwdata[BSCRC_CTRL_INIT]) begin
            st_next.result = hwdata[BSCRC_CTRL_VAL] ? BSCRC_INIT_ONES : BSCRC_INIT_ZERO;
          end
        end
        BSCRC_OFS_DATA: begin
          st_next.result[ln*8 +: 8] = wb;
          st_next.result_byte_pointer = st_reg.result_byte_pointer + 2'h1;
        end
        BSCRC_OFS_MIRROR: begin
          st_next.bit_mirror_register = wb;
        end
        default: begin
        end
      endcase
    end
    // Address phase: capture and prepare read data
    if (hready) begin
      st_next.ph_act = addr_phase;
      st_next.ph_write = hwrite;
      st_next.ph_addr = win_addr;
      st_next.rdata = 32'h00000000;
      if (addr_phase && !hwrite) begin
        case (win_addr)
          BSCRC_OFS_CTRL: begin
            st_next.rdata = {27'h0000000, st_next.polynomial_select, 1'b0,
                             st_next.start_value_select, st_next.result_byte_pointer};
          end
          BSCRC_OFS_DATA: begin
            st_next.rdata = {24'h000000, st_next.result[lane(st_next.result_byte_pointer,
                             st_next.polynomial_select)*8 +: 8]};
            st_next.result_byte_pointer = st_next.result_byte_pointer + 2'h1;
          end
          BSCRC_OFS_MIRROR: begin
            st_next.rdata = {24'h000000, mirror(st_next.bit_mirror_register)};
          end
          BSCRC_OFS_STATUS: begin
            st_next.rdata = {30'h00000000, fifo_in_ready, fifo_out_valid};
          end
          default: begin
          end
        endcase
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule

//--- tb/bscrc_top_sva.sv
// Checker for the checksum unit, watching only the bus ports.
// Assumes one master whose hready is the unit's own hreadyout.
module bscrc_sva
  import bscrc_pkg::*;
#(
  parameter int FIFO_DEPTH = 32
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic dp_reg;
  logic dw_reg;
  logic [7:0] da_reg;
  logic [7:0] mir_reg;
  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_reg <= 1'h0;
      dw_reg <= 1'h0;
      da_reg <= 8'h0;
      mir_reg <= 8'h0;
    end else if (hready) begin
      dp_reg <= hsel && htrans[1];
      dw_reg <= hwrite;
      da_reg <= haddr[7:0];
      if (dp_reg && dw_reg && da_reg == BSCRC_OFS_MIRROR) begin
        mir_reg <= {<<{hwdata[7:0]}};
      end
    end
  end
  sequence s_rd(logic [7:0] a);
    dp_reg && !dw_reg && da_reg == a && hreadyout;
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  property p_mirror;
    s_rd(BSCRC_OFS_MIRROR) |-> hrdata == {24'h0, mir_reg};
  endproperty
  a_mirror: assert property (p_mirror) else $error("mirror read wrong");
  property p_input;
    s_rd(BSCRC_OFS_INPUT) |-> hrdata == 32'h0;
  endproperty
  a_input: assert property (p_input) else $error("input read not zero");
  property p_ctrl;
    s_rd(BSCRC_OFS_CTRL) |-> hrdata[31:5] == 27'h0 && !hrdata[3];
  endproperty
  a_ctrl: assert property (p_ctrl) else $error("control read bad");
  property p_stat;
    s_rd(BSCRC_OFS_STATUS) |-> hrdata[31:2] == 30'h0;
  endproperty
  a_stat: assert property (p_stat) else $error("status read bad");
  property p_wait;
    !hreadyout |-> dp_reg && dw_reg && da_reg == BSCRC_OFS_INPUT;
  endproperty
  a_wait: assert property (p_wait) else $error("stall outside input write");
  property p_bound;
    $fell(hreadyout) |-> ##[1:2] hreadyout;
  endproperty
  a_bound: assert property (p_bound) else $error("stall too long");
  property p_okay;
    hresp == 1'h0;
  endproperty
  a_okay: assert property (p_okay) else $error("response not okay");
  property p_rst;
    $rose(hresetn) |-> hreadyout && hrdata == 32'h0;
  endproperty
  a_rst: assert property (p_rst) else $error("bad state after reset");
endmodule

bind bscrc_top bscrc_sva #(.FIFO_DEPTH(FIFO_DEPTH)) bscrc_sva_i (.hclk(hclk),
  .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp));

//--- tb/bscrc_top_tb_top.sv
// Self-checking bench for the checksum unit over its bus.
// Assumes the unit is the only slave; reads are noted in a queue.
module bscrc_top_tb_top
  import bscrc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DEPTH = 4;
  logic hclk = 1'h0;
  logic hresetn = 1'h0;
  logic hwrite = 1'h0;
  logic dp = 1'h0;
  logic hreadyout;
  logic hresp;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [31:0] e;
  logic [31:0] want;
  logic [31:0] crc;
  logic [31:0] expq[$];
  logic [7:0] b;
  logic [7:0] m;
  int fails = 0;
  int samples_checked = 0;
  always #12.5 hclk = ~hclk;
  bscrc_top #(.FIFO_DEPTH(DEPTH)) bscrc_top_i (.hclk(hclk), .hresetn(hresetn),
    .hsel(1'h1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp));
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] step(input logic [31:0] c, input logic [7:0] d,
                                       input logic m16);
    logic [31:0] r;
    r = m16 ? c ^ {16'h0, d, 8'h0} : c ^ {24'h0, d};
    for (int i = 0; i < 8; i++) begin
      if (m16) r[15:0] = {r[14:0], 1'h0} ^ (r[15] ? BSCRC_POLY16 : 16'h0);
      else r = (r >> 1) ^ (r[0] ? BSCRC_POLY32_REFL : 32'h0);
    end
    return r;
  endfunction
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= BSCRC_HTRANS_NONSEQ;
    if (!w) expq.push_back(d);
    do @(posedge hclk); while (!hreadyout);
    htrans <= 2'h0;
    hwdata <= w ? d : 32'h0;
    do @(posedge hclk); while (!hreadyout);
  endtask
  task automatic run(input logic [4:0] c, input int n);
    int k;
    xfer(1'h1, BSCRC_OFS_CTRL, {27'h0, c});
    crc = c[2] ? BSCRC_INIT_ONES : BSCRC_INIT_ZERO;
    for (int i = 0; i < n; i++) begin
      b = 8'($urandom);
      xfer(1'h1, BSCRC_OFS_INPUT, {24'h0, b});
      crc = step(crc, b, c[4]);
    end
    // Right after an input write the queue still holds that byte
    if (n > 0) xfer(1'h0, BSCRC_OFS_STATUS, 32'h3);
    repeat (DEPTH + 2) @(posedge hclk);
    xfer(1'h0, BSCRC_OFS_STATUS, 32'h2);
    for (int i = 0; i < 4; i++) begin
      k = (c[1:0] + i) % 4;
      e = c[4] ? {24'h0, crc[8 * (k % 2) +: 8]} : {24'h0, crc[8 * k +: 8]};
      xfer(1'h0, BSCRC_OFS_DATA, e);
    end
    xfer(1'h0, BSCRC_OFS_CTRL, {27'h0, c[4], 1'h0, c[2], c[1:0]});
    $display("checksum test done, control %h, bytes %0d", c, n);
  endtask
  task automatic results;
    if (expq.size() != 0) fails++;
    $display("checks %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge hclk) begin
    if (dp && hreadyout) begin
      want = expq.pop_front();
      samples_checked++;
      if (hrdata !== want) begin
        fails++;
        $display("Error hrdata expected %h seen %h", want, hrdata);
      end
    end
    if (hreadyout) dp <= htrans[1] && !hwrite;
  end
  initial begin
    #400000;
    fails++;
    results();
  end
  initial begin
    void'($urandom(32'hEBB494B5));
    repeat (10) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    xfer(1'h0, BSCRC_OFS_CTRL, 32'h0);
    xfer(1'h0, BSCRC_OFS_STATUS, 32'h2);
    xfer(1'h0, 8'h14, 32'h0);
    xfer(1'h0, BSCRC_OFS_INPUT, 32'h0);
    $display("register reset test done");
    for (int i = 0; i < 4; i++) begin
      b = 8'($urandom);
      m = {<<{b}};
      xfer(1'h1, BSCRC_OFS_MIRROR, {24'h0, b});
      xfer(1'h0, BSCRC_OFS_MIRROR, {24'h0, m});
    end
    $display("mirror test done");
    xfer(1'h1, BSCRC_OFS_CTRL, 32'h0);
    crc = $urandom;
    for (int i = 0; i < 4; i++) begin
      xfer(1'h1, BSCRC_OFS_DATA, {24'h0, crc[8 * i +: 8]});
    end
    xfer(1'h0, BSCRC_OFS_CTRL, 32'h0);
    for (int i = 0; i < 4; i++) begin
      xfer(1'h0, BSCRC_OFS_DATA, {24'h0, crc[8 * i +: 8]});
    end
    $display("window test done");
    xfer(1'h1, BSCRC_OFS_CTRL, 32'h17);
    hresetn <= 1'h0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    xfer(1'h0, BSCRC_OFS_CTRL, 32'h0);
    xfer(1'h0, BSCRC_OFS_DATA, 32'h0);
    $display("mid-run reset test done");
    for (int i = 0; i < 12; i++) begin
      run({i[1], 1'h1, i[0], i[3:2]}, $urandom_range(0, 7));
    end
    // Let the monitor take the last read before the verdict
    repeat (2) @(posedge hclk);
    results();
  end
endmodule
